// ---- pcit_buf2.sv ----
// Two-entry buffer with registered head word and registered flags
`timescale 1ns/1ps
`default_nettype none
module pcit_buf2 import pcit_pkg::*; #(
	parameter int W = DATA_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Filling side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);

	logic head_v_q;
	logic spare_v_q;
	logic [W-1:0] head_q;
	logic [W-1:0] spare_q;

	// Handshakes; full only when the spare slot is taken
	wire push = in_valid & ~spare_v_q;
	wire pop = head_v_q & out_ready;

	assign in_ready = ~spare_v_q;
	assign out_valid = head_v_q;
	assign out_data = head_q;

	// Head always holds the oldest word so the reader sees it from a register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			head_v_q <= 1'b0;
			spare_v_q <= 1'b0;
			head_q <= '0;
			spare_q <= '0;
		end else if (pop) begin
			if (spare_v_q) begin
				head_q <= spare_q;
				spare_v_q <= push;
				if (push) begin
					spare_q <= in_data;
				end
			end else if (push) begin
				head_q <= in_data;
			end else begin
				head_v_q <= 1'b0;
			end
		end else if (push) begin
			if (!head_v_q) begin
				head_q <= in_data;
				head_v_q <= 1'b1;
			end else begin
				spare_q <= in_data;
				spare_v_q <= 1'b1;
			end
		end
	end

	// Words come out in the order they went in, never more than two held
	AST_BUF_NO_OVERFLOW: assert property (@(posedge sys_clk) disable iff (srst)
		spare_v_q |-> head_v_q)
		else $error("spare slot full while head empty");

endmodule
`default_nettype wire

// ---- pcit_init_model.sv ----
// Bus initiator model that runs single and burst cycles against the target pins
`timescale 1ns/1ps
`default_nettype none
module pcit_init_model import pcit_pkg::*; (
	// Clock
	input wire logic sys_clk,
	// Target pins as seen on the bus, released lines pulled high
	input wire logic devsel_n,
	input wire logic trdy_n,
	input wire logic stop_n,
	input wire logic [DATA_W-1:0] ad_bus,
	// Initiator pins
	output logic frame_n,
	output logic irdy_n,
	output logic idsel,
	output logic [3:0] cbe_n,
	output logic [DATA_W-1:0] m_ad,
	output logic m_oe
);
	// Results of the last cycle, read back by the bench
	logic [DATA_W-1:0] rdat [8];
	int nd;
	int t_stop;
	logic claimed;
	logic stop_first;
	logic fin;

	// Idle bus from time zero
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		idsel = 1'b0;
		cbe_n = 4'hF;
		m_ad = '0;
		m_oe = 1'b0;
	end

	// One edge; undriven AD toggles so stale data never passes for valid
	task automatic step;
		@(posedge sys_clk);
		if (!m_oe)
			m_ad <= ~m_ad;
	endtask

	// One cycle of n phases, iw wait states before the first phase
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic sel, input int n,
		input int iw, input logic [31:0] wd);
		int w;
		logic ab;
		logic ih1, ih2, ir_old;
		w = iw;
		ab = 1'b0;
		ih1 = 1'b1;
		ih2 = 1'b1;
		nd = 0;
		t_stop = 0;
		claimed = 1'b0;
		stop_first = 1'b1;
		fin = 1'b0;
		// Plain edge: AD is driven right below, so no float toggle here
		@(posedge sys_clk);
		frame_n <= 1'b0;
		cbe_n <= cmd;
		m_ad <= addr;
		m_oe <= 1'b1;
		idsel <= sel;
		for (int cyc = 1; cyc < 60 && !fin; cyc++) begin
			step;
			// Target sees IRDY two clocks late, so a phase completes on that delayed view
			ir_old = ih2;
			ih2 = ih1;
			ih1 = irdy_n;
			if (!devsel_n)
				claimed = 1'b1;
			if (!stop_n && t_stop == 0)
				t_stop = cyc;
			if (cyc == 1) begin
				idsel <= 1'b0;
				cbe_n <= 4'h0;
				m_oe <= cmd[0];
				m_ad <= cmd[0] ? wd : ~addr;
			end
			if (irdy_n && !ab) begin
				if (w == 0) begin
					irdy_n <= 1'b0;
					if (n == 1)
						frame_n <= 1'b1;
				end else
					w--;
			end else if (!irdy_n && !ir_old && (!trdy_n || !stop_n)) begin
				if (!trdy_n) begin
					if (nd == 0)
						stop_first = stop_n;
					rdat[nd] = ad_bus;
					nd++;
					if (cmd[0])
						m_ad <= wd + DATA_W'(nd);
				end
				if (frame_n) begin
					irdy_n <= 1'b1;
					m_oe <= 1'b0;
					fin = 1'b1;
				end else if (!stop_n || nd == n - 1)
					frame_n <= 1'b1;
			end
			if (ab) begin
				irdy_n <= 1'b1;
				m_oe <= 1'b0;
				fin = 1'b1;
			end else if (cyc == 12 && !claimed) begin
				frame_n <= 1'b1;
				ab = 1'b1;
			end
		end
		// Bus stays idle so the target sees the end before the next cycle
		repeat (6) step;
	endtask
endmodule
`default_nettype wire

// ---- pcit_pkg.sv ----
// Shared constants and types for the bus target port
package pcit_pkg;

	// Bus command codes as seen on the command/byte-enable lines
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;
	localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
	localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
	localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

	// Address-phase encodings in the two low address bits
	localparam logic [1:0] BURST_LINEAR = 2'h0;
	localparam logic [1:0] CFG_TYPE0 = 2'h0;

	// Base address regions: index 0 is the operation registers, 1 to 4 the data FIFO
	localparam int NUM_BARS = 5;
	localparam int BAR_OPREG = 0;

	// First data phase of a FIFO read must start within this many bus clocks
	localparam int FIRST_PHASE_CLKS = 16;
	localparam int WAIT_W = 5;

	// Data path width and write buffer depth
	localparam int DATA_W = 32;
	localparam int BUF_DEPTH = 2;

	typedef enum logic [2:0] {ST_IDLE, ST_CLAIM, ST_DATA, ST_RELEASE, ST_BUSWAIT} pcit_state_e;
	typedef enum logic [1:0] {RG_OPREG, RG_CFG, RG_ROM, RG_FIFO} pcit_region_e;

	// Bus inputs travelling together through the synchroniser
	typedef struct packed {
		logic frame_n;
		logic irdy_n;
		logic idsel;
		logic [3:0] cbe_n;
		logic [DATA_W-1:0] ad;
	} pcit_bus_s;

	// Request towards the register, configuration and ROM logic
	typedef struct packed {
		logic valid;
		pcit_region_e space;
		logic we;
		logic [3:0] be_n;
		logic [DATA_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pcit_regreq_s;

	// Reset values
	localparam pcit_bus_s BUS_IDLE = '{frame_n: 1'b1, irdy_n: 1'b1, idsel: 1'b0, cbe_n: 4'hF, ad: 32'h0};
	localparam pcit_regreq_s REQ_IDLE = '{valid: 1'b0, space: RG_OPREG, we: 1'b0, be_n: 4'hF,
		addr: 32'h0, wdata: 32'h0};

endpackage

// ---- pcit_target.sv ----
// Target-only bus transaction port: decode, claim, wait states and terminations
// Notes on behaviour
// - Address phase is the clock frame goes active; command is latched, address only for non-FIFO reads.
// - Reads leave a turn-around clock with AD undriven; writes go straight to data.
// - Claim only the nine supported I/O, memory and configuration commands.
// - Read-multiple and read-line act as memory read; write-invalidate as write.
// - Final phase is flagged by frame inactive and completes on both ready signals.
// - Each data phase takes at least one clock; wait states are whole clocks.
// - Transaction ends only when both frame and initiator ready are inactive.
// - Non-linear burst order gets stop with data in its first phase.
// - Configuration, operation register and ROM bursts disconnect after one phase.
// - Ready on reads only with valid data; no claim during the address phase.
// - Operation register read stops in clock 3 only if burst seen in clock 2.
// - FIFO read with no data ends with stop and no ready.
// - ROM read is retried until the serial memory has fetched four bytes.
// - Operation register writes always get stop in clock 3.
// - FIFO write while full ends with stop and no ready.
// - FIFO write bursts go on while the FIFO has room.
// - Disconnect drives stop, ready and select together and moves data.
// - Retry drives stop and select without ready; no data moves.
// - First FIFO read phase is retried if no data within 16 clocks of frame.
// - Never answer with a target abort.
`timescale 1ns/1ps
`default_nettype none
module pcit_target import pcit_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Bus pins from the initiator
	input wire logic frame_n_in,
	input wire logic irdy_n_in,
	input wire logic idsel_in,
	input wire logic [3:0] cbe_n_in,
	input wire logic [DATA_W-1:0] ad_in,
	// Bus pins driven by the target
	output logic [DATA_W-1:0] ad_out,
	output logic ad_oe,
	output logic devsel_n_out,
	output logic trdy_n_out,
	output logic stop_n_out,
	output logic tgt_oe,
	// Region setup from configuration logic
	input wire logic [NUM_BARS-1:0][DATA_W-1:0] bar_base,
	input wire logic [NUM_BARS-1:0][DATA_W-1:0] bar_mask,
	input wire logic [NUM_BARS-1:0] bar_io,
	input wire logic rom_en,
	input wire logic [DATA_W-1:0] rom_base,
	input wire logic [DATA_W-1:0] rom_mask,
	// Register, configuration and ROM access
	output var pcit_regreq_s loc_req,
	input wire logic [DATA_W-1:0] loc_rdata,
	input wire logic rom_ready,
	// Add-on write stream
	output logic wr_valid,
	output logic [DATA_W-1:0] wr_data,
	input wire logic wr_ready,
	// Add-on read stream
	input wire logic rd_valid,
	input wire logic [DATA_W-1:0] rd_data,
	output logic rd_ready
);

	pcit_bus_s sync1_q;
	pcit_bus_s bus_q;
	logic frame_prev_q;
	pcit_state_e state_q;
	pcit_state_e state_d;
	pcit_region_e region_q;
	logic we_q;
	logic wrap_q;
	logic first_q;
	logic [WAIT_W-1:0] wait_q;
	logic devsel_q;
	logic trdy_q;
	logic stop_q;
	logic tgt_oe_q;
	logic ad_oe_q;
	logic [DATA_W-1:0] ad_out_q;
	logic rd_ready_q;
	logic gap_q;
	pcit_regreq_s req_q;
	logic buf_in_ready;

	// Two flip-flops on every bus pin before any logic looks at it
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync1_q <= BUS_IDLE;
			bus_q <= BUS_IDLE;
			frame_prev_q <= 1'b1;
		end else begin
			sync1_q <= {frame_n_in, irdy_n_in, idsel_in, cbe_n_in, ad_in};
			bus_q <= sync1_q;
			frame_prev_q <= bus_q.frame_n;
		end
	end

	// Address phase and command decode; aliases fold onto plain read and write
	wire addr_phase = frame_prev_q & ~bus_q.frame_n;
	wire [3:0] cmd = bus_q.cbe_n;
	wire cmd_rd = (cmd == CMD_IO_RD) | (cmd == CMD_MEM_RD) | (cmd == CMD_CFG_RD)
		| (cmd == CMD_MEM_RD_MULT) | (cmd == CMD_MEM_RD_LINE);
	wire cmd_wr = (cmd == CMD_IO_WR) | (cmd == CMD_MEM_WR) | (cmd == CMD_CFG_WR)
		| (cmd == CMD_MEM_WR_INV);
	wire cmd_cfg = (cmd == CMD_CFG_RD) | (cmd == CMD_CFG_WR);
	wire cmd_io = (cmd == CMD_IO_RD) | (cmd == CMD_IO_WR);
	wire cmd_mem = (cmd_rd | cmd_wr) & ~cmd_cfg & ~cmd_io;

	// Region match per base address register
	logic [NUM_BARS-1:0] bar_hit;
	for (genvar i = 0; i < NUM_BARS; i++) begin : g_bar
		assign bar_hit[i] = ((bus_q.ad & bar_mask[i]) == bar_base[i]) & (bar_io[i] ? cmd_io : cmd_mem);
	end

	// Claim decision; unsupported commands never match anything
	wire rom_hit = rom_en & cmd_mem & ((bus_q.ad & rom_mask) == rom_base);
	wire cfg_hit = cmd_cfg & bus_q.idsel & (bus_q.ad[1:0] == CFG_TYPE0);
	wire fifo_hit = |bar_hit[NUM_BARS-1:1];
	wire any_hit = addr_phase & (cfg_hit | bar_hit[BAR_OPREG] | rom_hit | fifo_hit);
	wire pcit_region_e region_d = cfg_hit ? RG_CFG : bar_hit[BAR_OPREG] ? RG_OPREG : rom_hit ? RG_ROM : RG_FIFO;
	wire wrap_d = cmd_mem & (bus_q.ad[1:0] != BURST_LINEAR);

	// Data phase bookkeeping
	wire done = trdy_q & ~bus_q.irdy_n;
	wire in_claim = state_q == ST_CLAIM;
	wire burst_seen = in_claim & ~bus_q.frame_n & ~bus_q.irdy_n;
	wire is_fifo = region_q == RG_FIFO;
	wire wait_hit = wait_q == WAIT_W'(FIRST_PHASE_CLKS - 1);
	// Two dead clocks after each phase: pins reach the logic two clocks late, new data needs that long
	wire can_offer = in_claim | ((state_q == ST_DATA) & ~trdy_q & ~stop_q & ~gap_q);
	wire rom_wait = (region_q == RG_ROM) & ~we_q & ~rom_ready;
	wire single_ok = first_q & ~rom_wait;
	wire fifo_ok = we_q ? buf_in_ready : rd_valid;
	wire data_ok = is_fifo ? fifo_ok : single_ok;

	// Registers stop after one phase; writes always, reads on a seen burst or while ROM data is not ready
	wire single_stop = ~single_ok | we_q | burst_seen;
	// FIFO reads may wait for the add-on, but only inside the first-phase window
	wire fifo_stop = data_ok ? wrap_q & first_q : (we_q | ~first_q | wait_hit);
	wire give_trdy = can_offer & data_ok;
	wire give_stop = can_offer & (is_fifo ? fifo_stop : single_stop);

	// Transaction sequencing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (any_hit) begin
					state_d = ST_CLAIM;
				end
			end
			ST_CLAIM: begin
				state_d = ST_DATA;
			end
			ST_DATA: begin
				if (bus_q.frame_n & bus_q.irdy_n) begin
					state_d = ST_RELEASE;
				end else if (bus_q.frame_n & (done | (stop_q & ~trdy_q))) begin
					state_d = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				state_d = ST_BUSWAIT;
			end
			ST_BUSWAIT: begin
				if (bus_q.frame_n & bus_q.irdy_n) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// Target control lines; stop is never raised without select
	wire in_data_next = state_d == ST_DATA;
	wire trdy_d = in_data_next & (give_trdy | (trdy_q & ~done));
	wire stop_d = in_data_next & (stop_q | give_stop);
	wire devsel_d = (state_d == ST_CLAIM) | in_data_next;
	wire tgt_oe_d = devsel_d | (state_d == ST_RELEASE);
	wire ad_oe_d = in_data_next & ~we_q;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			devsel_q <= 1'b0;
			trdy_q <= 1'b0;
			stop_q <= 1'b0;
			tgt_oe_q <= 1'b0;
			ad_oe_q <= 1'b0;
			gap_q <= 1'b0;
		end else begin
			gap_q <= done;
			state_q <= state_d;
			devsel_q <= devsel_d;
			trdy_q <= trdy_d;
			stop_q <= stop_d;
			tgt_oe_q <= tgt_oe_d;
			ad_oe_q <= ad_oe_d;
		end
	end

	// Cycle context latched in the address phase
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			region_q <= RG_OPREG;
			we_q <= 1'b0;
			wrap_q <= 1'b0;
			first_q <= 1'b0;
			wait_q <= '0;
		end else if (state_q == ST_IDLE) begin
			region_q <= region_d;
			we_q <= cmd_wr;
			wrap_q <= wrap_d;
			first_q <= 1'b1;
			wait_q <= WAIT_W'(1);
		end else begin
			first_q <= first_q & ~done;
			wait_q <= wait_hit ? wait_q : wait_q + WAIT_W'(1);
		end
	end

	// Read data is loaded only when ready is offered, so it is stable under ready
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ad_out_q <= '0;
			rd_ready_q <= 1'b0;
		end else begin
			if (give_trdy & ~we_q) begin
				ad_out_q <= is_fifo ? rd_data : loc_rdata;
			end
			rd_ready_q <= done & is_fifo & ~we_q;
		end
	end

	// Register port: reads issued at claim, writes once their data phase completes
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			req_q <= REQ_IDLE;
		end else if (any_hit & cmd_rd & (region_d != RG_FIFO)) begin
			req_q <= '{valid: 1'b1, space: region_d, we: 1'b0, be_n: 4'h0, addr: bus_q.ad, wdata: req_q.wdata};
		end else if (done & we_q & ~is_fifo) begin
			req_q <= '{valid: 1'b1, space: region_q, we: 1'b1, be_n: bus_q.cbe_n, addr: req_q.addr,
				wdata: bus_q.ad};
		end else begin
			req_q.valid <= 1'b0;
		end
	end

	// FIFO writes land in a small buffer so a stalled add-on loses no word
	pcit_buf2 #(.W(DATA_W)) u_wbuf (
		.sys_clk(sys_clk),
		.srst(srst),
		.in_valid(done & we_q & is_fifo),
		.in_data(bus_q.ad),
		.in_ready(buf_in_ready),
		.out_valid(wr_valid),
		.out_data(wr_data),
		.out_ready(wr_ready)
	);

	// Pin drive: asserted levels are low on the wire
	assign devsel_n_out = ~devsel_q;
	assign trdy_n_out = ~trdy_q;
	assign stop_n_out = ~stop_q;
	assign tgt_oe = tgt_oe_q;
	assign ad_oe = ad_oe_q;
	assign ad_out = ad_out_q;
	assign rd_ready = rd_ready_q;
	assign loc_req = req_q;

	AST_NO_ABORT: assert property (@(posedge sys_clk) disable iff (srst)
		stop_q |-> devsel_q)
		else $error("stop without select");

	AST_CLAIM_SUPPORTED: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(devsel_q) |-> $past(addr_phase & (cmd_rd | cmd_wr)))
		else $error("claimed an unsupported command");

	AST_READ_TURNAROUND: assert property (@(posedge sys_clk) disable iff (srst)
		(in_claim & ~we_q) |-> ~ad_oe_q ##1 ad_oe_q)
		else $error("read turn-around not kept");

	AST_READY_WITH_DATA: assert property (@(posedge sys_clk) disable iff (srst)
		(trdy_q & ~we_q) |-> (ad_oe_q & (~$past(trdy_q) | $stable(ad_out_q))))
		else $error("read ready without stable data");

	AST_OPRD_BURST_STOP: assert property (@(posedge sys_clk) disable iff (srst)
		(in_claim & (region_q == RG_OPREG) & ~we_q) |=> (stop_q == $past(burst_seen)) & trdy_q)
		else $error("register read stop in clock 3 wrong");

	AST_OPWR_STOP: assert property (@(posedge sys_clk) disable iff (srst)
		(in_claim & (region_q == RG_OPREG) & we_q) |=> stop_q & trdy_q & devsel_q)
		else $error("register write not disconnected in clock 3");

	AST_ROM_RETRY: assert property (@(posedge sys_clk) disable iff (srst)
		(in_claim & rom_wait) |=> stop_q & ~trdy_q)
		else $error("ROM read not retried");

	AST_FIFO_FULL_RETRY: assert property (@(posedge sys_clk) disable iff (srst)
		(in_claim & is_fifo & we_q & ~buf_in_ready) |=> stop_q & ~trdy_q)
		else $error("full FIFO write not retried");

	AST_WRAP_DISCONNECT: assert property (@(posedge sys_clk) disable iff (srst)
		(in_claim & is_fifo & wrap_q & (we_q ? buf_in_ready : rd_valid)) |=> stop_q & trdy_q)
		else $error("wrap burst not disconnected in first phase");

	AST_FIRST_READ_LIMIT: assert property (@(posedge sys_clk) disable iff (srst)
		(can_offer & is_fifo & ~we_q & first_q & ~rd_valid & wait_hit) |=> stop_q & ~trdy_q)
		else $error("slow first read not retried");

	AST_IDLE_AFTER_BUS: assert property (@(posedge sys_clk) disable iff (srst)
		(state_q == ST_BUSWAIT & bus_q.frame_n & bus_q.irdy_n) |=> (state_q == ST_IDLE) & ~tgt_oe_q)
		else $error("bus idle not taken as end of transaction");

endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the bus target port
`timescale 1ns/1ps
`default_nettype none
module tb_top import pcit_pkg::*; ;
	// Clock, reset, counters and pins
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	int err_count = 0;
	int comparisons = 0;
	logic frame_n, irdy_n, idsel, m_oe, ad_oe, devsel_n_out, trdy_n_out, stop_n_out, tgt_oe;
	logic [3:0] cbe_n;
	logic [DATA_W-1:0] m_ad, ad_out, wr_data, rd_data;
	pcit_regreq_s loc_req;
	logic rom_ready = 1'b1;
	logic rom_en = 1'b1;
	logic wr_ready = 1'b1;
	logic rd_en = 1'b0;
	logic wr_valid, rd_valid, rd_ready;
	logic [DATA_W-1:0] rd_cnt = '0;
	logic [DATA_W-1:0] lw_data = '0;
	pcit_region_e lw_sp = RG_FIFO;
	logic [3:0] lw_be = 4'hF;
	logic [DATA_W-1:0] wq [32];
	int wn = 0;
	logic [DATA_W-1:0] rdat [8];
	int nd, ts;
	logic cl, sf;

	// Register side answers with a fixed scramble of the address
	function automatic logic [31:0] lx(input logic [31:0] a);
		return a ^ 32'h5A5A_5A5A;
	endfunction

	// Released target lines float high; read stream counts up
	wire logic devsel_w = tgt_oe ? devsel_n_out : 1'b1;
	wire logic trdy_w = tgt_oe ? trdy_n_out : 1'b1;
	wire logic stop_w = tgt_oe ? stop_n_out : 1'b1;
	wire logic [DATA_W-1:0] ad_w = ad_oe ? ad_out : m_ad;
	wire logic [DATA_W-1:0] loc_rdata = lx(loc_req.addr);
	assign rd_valid = rd_en;
	assign rd_data = 32'hC000_0000 + rd_cnt;

	pcit_target pcit_target_inst (.sys_clk, .srst, .frame_n_in(frame_n), .irdy_n_in(irdy_n), .idsel_in(idsel),
		.cbe_n_in(cbe_n), .ad_in(ad_w), .ad_out, .ad_oe, .devsel_n_out, .trdy_n_out, .stop_n_out, .tgt_oe,
		.bar_base({32'h7100_0000, 32'h7000_0000, 32'h0000_3000, 32'h2000_0000, 32'h1000_0000}),
		.bar_mask({5{32'hFFFF_FF00}}), .bar_io(5'h04), .rom_en, .rom_base(32'h4000_0000),
		.rom_mask(32'hFFFF_F800), .loc_req, .loc_rdata, .rom_ready, .wr_valid, .wr_data, .wr_ready,
		.rd_valid, .rd_data, .rd_ready);

	pcit_init_model pcit_init_model_inst (.sys_clk, .devsel_n(devsel_w), .trdy_n(trdy_w), .stop_n(stop_w),
		.ad_bus(ad_w), .frame_n, .irdy_n, .idsel, .cbe_n, .m_ad, .m_oe);

	task automatic fail(input string m);
		err_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1)
			fail(m);
	endtask

	// Local sinks and per-edge bus sanity
	always @(posedge sys_clk) begin
		if (rd_ready)
			rd_cnt <= rd_cnt + 1;
		if (wr_valid && wr_ready) begin
			wq[wn] <= wr_data;
			wn <= wn + 1;
		end
		if (loc_req.valid && loc_req.we) begin
			lw_data <= loc_req.wdata;
			lw_sp <= loc_req.space;
			lw_be <= loc_req.be_n;
		end
		if (tgt_oe === 1'b1 && stop_n_out === 1'b0 && devsel_n_out !== 1'b0)
			fail("abort termination");
		if (ad_oe === 1'b1 && m_oe === 1'b1)
			fail("AD driven by both");
	end

	task automatic go(input logic [3:0] c, input logic [31:0] a, input logic s, input int n, input int iw,
		input logic [31:0] wd);
		pcit_init_model_inst.xfer(c, a, s, n, iw, wd);
		rdat = pcit_init_model_inst.rdat;
		nd = pcit_init_model_inst.nd;
		ts = pcit_init_model_inst.t_stop;
		cl = pcit_init_model_inst.claimed;
		sf = pcit_init_model_inst.stop_first;
		chk(pcit_init_model_inst.fin && tgt_oe === 1'b0, "cycle not ended");
	endtask

	// All sixteen command codes, single phase
	task automatic t_cmds;
		logic [3:0] c;
		logic [31:0] a;
		logic sup;
		for (int i = 0; i < 16; i++) begin
			c = 4'(i);
			sup = c inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
			a = (c[3:1] == 3'h1) ? 32'h0000_3004 : (c[3:1] == 3'h5) ? 32'h0000_0010 : 32'h1000_0010;
			go(c, a, c[3:1] == 3'h5, 1, 0, 32'h1234_0000 + 32'(i));
			chk(cl === sup, "claim by command");
			if (sup && c[3:1] != 3'h1) begin
				chk(nd == 1 && sf === !c[0], "single phase stop");
				chk(c[0] ? lw_data === 32'h1234_0000 + 32'(i) : rdat[0] === lx(a), "data");
				if (c[0])
					chk(lw_sp === (c[3:1] == 3'h5 ? RG_CFG : RG_OPREG) && lw_be === 4'h0, "write space");
			end
		end
	endtask

	// Bursts to registers, configuration and ROM
	task automatic t_noburst;
		go(CMD_MEM_RD, 32'h1000_0020, 1'b0, 3, 0, '0);
		chk(nd == 1 && sf === 1'b0 && rdat[0] === lx(32'h1000_0020), "reg burst");
		go(CMD_MEM_RD, 32'h1000_0020, 1'b0, 3, 2, '0);
		chk(nd == 1 && sf === 1'b1, "wait states seen as burst");
		go(CMD_CFG_RD, 32'h0000_0008, 1'b1, 2, 0, '0);
		chk(nd == 1 && rdat[0] === lx(32'h8), "cfg burst");
		go(CMD_MEM_WR, 32'h1000_0030, 1'b0, 3, 1, 32'hBEEF_0001);
		chk(nd == 1 && sf === 1'b0 && lw_data === 32'hBEEF_0001, "reg burst write");
		@(posedge sys_clk);
		rom_ready <= 1'b0;
		go(CMD_MEM_RD, 32'h4000_0004, 1'b0, 1, 0, '0);
		chk(cl === 1'b1 && nd == 0 && ts > 0, "ROM not retried");
		@(posedge sys_clk);
		rom_ready <= 1'b1;
		go(CMD_MEM_RD, 32'h4000_0004, 1'b0, 2, 0, '0);
		chk(nd == 1 && rdat[0] === lx(32'h4000_0004), "ROM burst");
		@(posedge sys_clk);
		rom_en <= 1'b0;
		go(CMD_MEM_RD, 32'h4000_0004, 1'b0, 1, 0, '0);
		chk(cl === 1'b0, "disabled ROM claimed");
		go(CMD_MEM_RD, 32'h5000_0000, 1'b0, 1, 0, '0);
		chk(cl === 1'b0, "miss claimed");
		go(CMD_CFG_RD, 32'h0000_0008, 1'b0, 1, 0, '0);
		chk(cl === 1'b0, "unselected cfg claimed");
	endtask

	// FIFO reads: empty, linear burst, wrap order
	task automatic t_fifo_rd;
		logic [31:0] last;
		go(CMD_MEM_RD, 32'h2000_0000, 1'b0, 1, 0, '0);
		chk(cl === 1'b1 && nd == 0 && ts > 0 && ts <= FIRST_PHASE_CLKS + 4, "empty read");
		@(posedge sys_clk);
		rd_en <= 1'b1;
		go(CMD_MEM_RD_MULT, 32'h2000_0000, 1'b0, 4, 0, '0);
		chk(nd == 4 && rdat[0][31:28] === 4'hC, "FIFO burst read");
		for (int i = 1; i < 4; i++)
			chk(rdat[i] === rdat[0] + 32'(i), "read order");
		last = rdat[3];
		go(CMD_MEM_RD_LINE, 32'h2000_0002, 1'b0, 3, 0, '0);
		chk(nd == 1 && sf === 1'b0 && rdat[0] === last + 1, "wrap burst");
	endtask

	// FIFO writes: free burst, stalled far side, retry and repeat
	task automatic t_fifo_wr;
		int b;
		b = wn;
		go(CMD_MEM_WR_INV, 32'h2000_0000, 1'b0, 5, 0, 32'hD000_0000);
		repeat (4) @(posedge sys_clk);
		chk(nd == 5 && wn == b + 5, "burst write");
		for (int i = 0; i < 5; i++)
			chk(wq[b + i] === 32'hD000_0000 + 32'(i), "write order");
		wr_ready <= 1'b0;
		go(CMD_MEM_WR, 32'h2000_0000, 1'b0, 5, 0, 32'hE000_0000);
		chk(nd == BUF_DEPTH, "burst into stalled buffer");
		go(CMD_MEM_WR, 32'h2000_0000, 1'b0, 1, 0, 32'hF000_0000);
		chk(cl === 1'b1 && nd == 0 && ts > 0, "full write not retried");
		wr_ready <= 1'b1;
		go(CMD_MEM_WR, 32'h2000_0000, 1'b0, 1, 0, 32'hF000_0000);
		repeat (4) @(posedge sys_clk);
		chk(nd == 1 && wn == b + 8 && wq[b + 5] === 32'hE000_0000 && wq[b + 6] === 32'hE000_0001
			&& wq[b + 7] === 32'hF000_0000, "stalled words lost");
	endtask

	task automatic tally_and_finish;
		if (err_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Clock
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end

	// Watchdog well past the expected several hundred cycles
	initial begin
		#(8 * 20000);
		fail("watchdog");
		tally_and_finish;
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(tgt_oe === 1'b0 && ad_oe === 1'b0 && wr_valid === 1'b0 && rd_ready === 1'b0, "reset state");
		t_cmds;
		t_noburst;
		t_fifo_rd;
		t_fifo_wr;
		tally_and_finish;
	end
endmodule
`default_nettype wire
